// ---- rx_frame_filter_buffer.sv ----
// Receive MAC: frame acceptance, packet buffer, APB registers
// Summary of operation
// [RL1] Whole frame received and CRC known before acceptance is decided.
// [RL2] Mode field 00 normal, 10 error, 01 promiscuous; reset to normal.
// [RL3] Normal mode keeps only good-CRC frames with a legal frame type.
// [RL4] Beacons need matching source PAN unless local PAN is broadcast.
// [RL5] Destination PAN must match local PAN or broadcast.
// [RL6] Short destination matches local or broadcast; extended matches local.
// [RL7] Source-only data or command needs coordinator role and matching PAN.
// [RL8] Error mode keeps frames with good or bad CRC.
// [RL9] Promiscuous mode keeps every good-CRC frame, no address checks.
// [RL10] Type filter: 000 all, 100 command, 010 data, 001 beacon.
// [RL11] Kept good-CRC frame with acknowledge request triggers an automatic acknowledge.
// [RL12] Acknowledge carries the received sequence number.
// [RL13] Receive done flag set once the frame sits in the buffer.
// [RL14] Reading the interrupt flag register clears it; host keeps the copy.
// [RL15] Host reads the buffer at indexes 0x300 to 0x38F.
// [RL16] First buffer byte is frame length including two check bytes.
// [RL17] Link quality then signal strength follow the check bytes.
// [RL18] 128-byte buffer filled one byte at a time by a write pointer.
// [RL19] Pointer resets on first-byte read, flush or software reset.
// [RL20] Flush bit resets the pointer and clears itself.
// [RL21] One packet held; reading first byte frees the buffer.
// [RL22] Decode block bit stops reception of new frames.
// [RL23] Host reads data, quality and strength from index 0x301 onward.
// [RL24] Frames arriving while the buffer is unread are discarded.
`timescale 1ns/1ps
`default_nettype none
`include "rx_filter_cfg.svh"
module rx_frame_filter_buffer #(
  parameter int DEPTH = 128
) (
  input wire logic clk_i,
  input wire logic reset_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Demodulator byte stream
  input wire logic rx_sync_i,
  input wire logic rx_byte_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_end_i,
  input wire logic rx_crc_ok_i,
  input wire logic [7:0] rx_lqi_i,
  input wire logic [7:0] rx_rssi_i,
  // Request to the transmit MAC engine
  output logic ack_req_o,
  output logic [7:0] ack_seq_o,
  output logic rx_busy_o
);
  // All state in one word so reset and update stay in one place
  typedef struct packed {
    // Receive engine and write pointer
    rx_filter_pkg::rx_state_t st;
    logic [7:0] ptr;
    logic [7:0] cnt;
    logic full;
    // Frame status latched with the end marker
    logic crc_ok;
    logic [7:0] lqi;
    logic [7:0] rssi;
    // Configuration and command bits from the register port
    logic [1:0] mode;
    logic coord;
    logic [2:0] filt;
    logic flush;
    logic swrst;
    logic rx_done;
    logic decblk;
    logic [15:0] pan;
    logic [15:0] short_adr;
    logic [63:0] ext_adr;
    // Read word held for the whole access phase
    logic [31:0] prdata;
    // One-cycle request and number for the transmit side
    logic ack_req;
    logic [7:0] ack_seq;
  } main_state_t;

  main_state_t cur_ff;
  main_state_t nxt_cur;

  // Write and read sides of the packet buffer
  logic wr_en;
  logic [6:0] wr_idx;
  logic [7:0] wr_data;
  logic [6:0] rd_idx;
  logic [7:0] rd_data;
  logic [DEPTH-1:0][7:0] mem;
  // Verdict of the address and type filter
  logic accept;
  // Bus decode and per-cycle events
  logic setup;
  logic access;
  logic hit;
  logic in_buf;
  logic ptr_rst;
  logic done_set;
  logic [9:0] idx;
  logic [9:0] buf_off;

  // Word index decode; misaligned addresses are unmapped
  function automatic logic is_mapped(input logic [9:0] i, input logic [1:0] lo);
    logic ok;
    ok = (i == `RFC_IDX_MAC_CTRL) || (i == `RFC_IDX_FLUSH) ||
         (i == `RFC_IDX_SOFTRST) || (i == `RFC_IDX_IRQ) ||
         (i == `RFC_IDX_BBREG) || (i == `RFC_IDX_PAN) ||
         (i == `RFC_IDX_SHORT) || (i == `RFC_IDX_EXT_LO) ||
         (i == `RFC_IDX_EXT_HI) ||
         (i >= `RFC_IDX_BUF_BASE && i <= `RFC_IDX_BUF_LAST);
    return ok && (lo == 2'b00);
  endfunction

  // Buffer byte index with guard against running past the end
  function automatic logic room(input logic [7:0] p);
    return p < 8'(DEPTH);
  endfunction

  // Buffer keeps its own flip-flops; the engine only steers the write port
  rx_packet_buffer #(
    .DEPTH(DEPTH)
  ) u_buf (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .wr_en_i(wr_en),
    .wr_idx_i(wr_idx),
    .wr_data_i(wr_data),
    .rd_idx_i(rd_idx),
    .rd_data_o(rd_data),
    .mem_o(mem)
  );

  // Filter looks at the stored bytes, so the decision waits for the last byte
  rx_addr_filter #(
    .DEPTH(DEPTH)
  ) u_filt (
    .mem_i(mem),
    .mode_i(cur_ff.mode),
    .filt_i(cur_ff.filt),
    .coord_i(cur_ff.coord),
    .crc_ok_i(cur_ff.crc_ok),
    .pan_i(cur_ff.pan),
    .short_i(cur_ff.short_adr),
    .ext_i(cur_ff.ext_adr),
    .accept_o(accept)
  );

  // Bus phase decode; zero wait states so pready stays high
  assign setup = psel_i && !penable_i;
  assign access = psel_i && penable_i;
  assign idx = paddr_i[11:2];
  assign hit = is_mapped(idx, paddr_i[1:0]);
  assign buf_off = idx - `RFC_IDX_BUF_BASE;
  // Top sixteen words of the buffer window read zero without an error
  assign in_buf = hit && (idx >= `RFC_IDX_BUF_BASE) && (buf_off < 10'(DEPTH));
  assign rd_idx = buf_off[6:0];

  always_comb begin
    nxt_cur = cur_ff;
    wr_en = 1'b0;
    wr_idx = '0;
    wr_data = '0;
    done_set = 1'b0;
    nxt_cur.ack_req = 1'b0;
    // Self-clearing command bits act for exactly one cycle
    nxt_cur.flush = 1'b0; // [RL20]
    nxt_cur.swrst = 1'b0;

    // Read data captured in setup so it comes from a flip-flop
    if (setup && !pwrite_i) begin
      nxt_cur.prdata = '0;
      // Buffer bytes sit in the low lane; upper bits read zero
      if (in_buf) begin
        nxt_cur.prdata = {24'h0000_00, rd_data}; // [RL15] [RL23]
      end else begin
        case (idx)
          `RFC_IDX_MAC_CTRL: begin
            nxt_cur.prdata[1:0] = cur_ff.mode;
            nxt_cur.prdata[`RFC_BIT_PANCOORD] = cur_ff.coord;
          end
          `RFC_IDX_FLUSH: nxt_cur.prdata[`RFC_FILT_MSB:`RFC_FILT_LSB] = cur_ff.filt;
          `RFC_IDX_IRQ: nxt_cur.prdata[`RFC_BIT_RXDONE] = cur_ff.rx_done;
          `RFC_IDX_BBREG: nxt_cur.prdata[`RFC_BIT_DECBLK] = cur_ff.decblk;
          `RFC_IDX_PAN: nxt_cur.prdata[15:0] = cur_ff.pan;
          `RFC_IDX_SHORT: nxt_cur.prdata[15:0] = cur_ff.short_adr;
          `RFC_IDX_EXT_LO: nxt_cur.prdata = cur_ff.ext_adr[31:0];
          `RFC_IDX_EXT_HI: nxt_cur.prdata = cur_ff.ext_adr[63:32];
          default: nxt_cur.prdata = '0;
        endcase
      end
    end

    // Register writes take effect on the access edge
    if (access && pwrite_i && hit) begin
      case (idx)
        `RFC_IDX_MAC_CTRL: begin
          nxt_cur.mode = pwdata_i[1:0]; // [RL2]
          nxt_cur.coord = pwdata_i[`RFC_BIT_PANCOORD];
        end
        `RFC_IDX_FLUSH: begin
          // Flush acts in the next cycle and reads back as zero
          nxt_cur.filt = pwdata_i[`RFC_FILT_MSB:`RFC_FILT_LSB]; // [RL10]
          nxt_cur.flush = pwdata_i[`RFC_BIT_FLUSH]; // [RL20]
        end
        // Software reset keeps the configuration registers
        `RFC_IDX_SOFTRST: nxt_cur.swrst = pwdata_i[`RFC_BIT_SWRST];
        `RFC_IDX_BBREG: nxt_cur.decblk = pwdata_i[`RFC_BIT_DECBLK]; // [RL22]
        `RFC_IDX_PAN: nxt_cur.pan = pwdata_i[15:0];
        `RFC_IDX_SHORT: nxt_cur.short_adr = pwdata_i[15:0];
        // Extended address spans two words, low word first
        `RFC_IDX_EXT_LO: nxt_cur.ext_adr[31:0] = pwdata_i;
        `RFC_IDX_EXT_HI: nxt_cur.ext_adr[63:32] = pwdata_i;
        default: nxt_cur.decblk = cur_ff.decblk;
      endcase
    end

    // Pointer reset sources; a frame in flight is abandoned too
    ptr_rst = cur_ff.flush || cur_ff.swrst ||
              (access && !pwrite_i && in_buf && rd_idx == 7'h00); // [RL19] [RL21]

    // Receive engine
    case (cur_ff.st)
      rx_filter_pkg::RX_IDLE: begin
        // Busy buffer or decode block: the frame is simply not taken
        if (rx_sync_i && !cur_ff.full && !cur_ff.decblk) begin // [RL22] [RL24]
          nxt_cur.st = rx_filter_pkg::RX_BODY;
          nxt_cur.ptr = `RFC_FIRST_DATA;
          nxt_cur.cnt = '0;
        end
      end
      rx_filter_pkg::RX_BODY: begin
        if (rx_byte_valid_i) begin
          // Bytes past the buffer end are counted but not kept
          if (room(cur_ff.ptr)) begin
            wr_en = 1'b1; // [RL18]
            wr_idx = cur_ff.ptr[6:0];
            wr_data = rx_byte_i;
            nxt_cur.ptr = cur_ff.ptr + 8'h01;
          end
          nxt_cur.cnt = cur_ff.cnt + 8'h01;
        end
        if (rx_end_i) begin
          // Status and quality bytes are only valid with the end pulse
          nxt_cur.crc_ok = rx_crc_ok_i; // [RL1]
          nxt_cur.lqi = rx_lqi_i;
          nxt_cur.rssi = rx_rssi_i;
          nxt_cur.st = rx_filter_pkg::RX_LQI;
        end
      end
      // Quality then strength go right after the check bytes
      rx_filter_pkg::RX_LQI: begin
        if (room(cur_ff.ptr)) begin
          wr_en = 1'b1; // [RL17]
          wr_idx = cur_ff.ptr[6:0];
          wr_data = cur_ff.lqi;
          nxt_cur.ptr = cur_ff.ptr + 8'h01;
        end
        nxt_cur.st = rx_filter_pkg::RX_RSSI;
      end
      rx_filter_pkg::RX_RSSI: begin
        if (room(cur_ff.ptr)) begin
          wr_en = 1'b1; // [RL17]
          wr_idx = cur_ff.ptr[6:0];
          wr_data = cur_ff.rssi;
          nxt_cur.ptr = cur_ff.ptr + 8'h01;
        end
        nxt_cur.st = rx_filter_pkg::RX_DECIDE;
      end
      // All bytes stored: the filter verdict is final now
      rx_filter_pkg::RX_DECIDE: begin
        // Length includes the two check bytes the demodulator passes on
        wr_en = 1'b1; // [RL16]
        wr_idx = 7'h00;
        wr_data = cur_ff.cnt;
        nxt_cur.st = rx_filter_pkg::RX_IDLE;
        if (accept) begin // [RL1]
          nxt_cur.full = 1'b1; // [RL21]
          done_set = 1'b1; // [RL13]
          // A bad-CRC frame kept in error mode is never acknowledged
          if (mem[`RFC_OFF_FC][`RFC_FC_ACKREQ] && cur_ff.crc_ok) begin
            nxt_cur.ack_req = 1'b1; // [RL11]
            nxt_cur.ack_seq = mem[`RFC_OFF_SEQ]; // [RL12]
          end
        end else begin
          // Rejected: the next frame overwrites this one from the start
          nxt_cur.ptr = `RFC_FIRST_DATA;
        end
      end
      default: nxt_cur.st = rx_filter_pkg::RX_IDLE;
    endcase

    // Pointer reset overrides the engine, including a frame half stored
    if (ptr_rst) begin
      nxt_cur.st = rx_filter_pkg::RX_IDLE; // [RL19]
      nxt_cur.ptr = `RFC_FIRST_DATA;
      nxt_cur.full = 1'b0; // [RL21]
      wr_en = 1'b0;
      done_set = 1'b0;
      nxt_cur.ack_req = 1'b0;
    end

    // Clear on read only what the captured word showed; a flag set after
    // the setup edge would otherwise be lost, and a completion now still wins
    if (access && !pwrite_i && hit && idx == `RFC_IDX_IRQ &&
        cur_ff.prdata[`RFC_BIT_RXDONE]) begin
      nxt_cur.rx_done = 1'b0; // [RL14]
    end
    if (done_set) begin
      nxt_cur.rx_done = 1'b1; // [RL13]
    end
    // Software reset drops a pending flag
    if (cur_ff.swrst) begin
      nxt_cur.rx_done = done_set;
    end
  end

  // State register; reset puts the pointer on the first data byte
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cur_ff <= '0;
      cur_ff.st <= rx_filter_pkg::RX_IDLE;
      cur_ff.ptr <= `RFC_FIRST_DATA;
      cur_ff.mode <= `RFC_MODE_NORMAL; // [RL2]
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Outputs
  assign prdata_o = cur_ff.prdata;
  assign pready_o = 1'b1;
  // Error only in the access phase, so a setup never flags
  assign pslverr_o = access && !hit;
  assign ack_req_o = cur_ff.ack_req;
  assign ack_seq_o = cur_ff.ack_seq;
  assign rx_busy_o = cur_ff.st != rx_filter_pkg::RX_IDLE;
endmodule
`default_nettype wire

// ---- rx_filter_cfg.svh ----
// Constants for the receive frame filter and packet buffer
`ifndef RX_FILTER_CFG_SVH
`define RX_FILTER_CFG_SVH
// Register word indexes; byte address is four times the index
`define RFC_IDX_MAC_CTRL 10'h000
`define RFC_IDX_FLUSH 10'h00D
`define RFC_IDX_SOFTRST 10'h02A
`define RFC_IDX_IRQ 10'h031
`define RFC_IDX_BBREG 10'h039
`define RFC_IDX_PAN 10'h040
`define RFC_IDX_SHORT 10'h041
`define RFC_IDX_EXT_LO 10'h042
`define RFC_IDX_EXT_HI 10'h043
`define RFC_IDX_BUF_BASE 10'h300
`define RFC_IDX_BUF_LAST 10'h38F
// Field positions
`define RFC_BIT_PANCOORD 3
`define RFC_BIT_FLUSH 0
`define RFC_FILT_LSB 1
`define RFC_FILT_MSB 3
`define RFC_BIT_RXDONE 3
`define RFC_BIT_DECBLK 2
`define RFC_BIT_SWRST 0
`define RFC_FC_ACKREQ 5
`define RFC_FC_PANC 6
// Receive modes
`define RFC_MODE_NORMAL 2'b00
`define RFC_MODE_ERROR 2'b10
`define RFC_MODE_PROMI 2'b01
// Frame types and addressing modes
`define RFC_FT_BEACON 3'h0
`define RFC_FT_DATA 3'h1
`define RFC_FT_CMD 3'h3
`define RFC_AM_NONE 2'h0
`define RFC_AM_RSVD 2'h1
`define RFC_AM_SHORT 2'h2
`define RFC_AM_EXT 2'h3
// Frame byte positions inside the buffer (index 0 is the length)
`define RFC_OFF_FC 8'h01
`define RFC_OFF_SEQ 8'h03
`define RFC_OFF_DPAN 8'h04
`define RFC_OFF_DADR 8'h06
`define RFC_LEN_SHORT 8'h02
`define RFC_LEN_EXT 8'h08
`define RFC_BCAST 16'hFFFF
`define RFC_FIRST_DATA 8'h01
`endif

// ---- rx_filter_pkg.sv ----
// Types shared by the receive filter and buffer
package rx_filter_pkg;
  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_BODY = 5'b00010,
    RX_LQI = 5'b00100,
    RX_RSSI = 5'b01000,
    RX_DECIDE = 5'b10000
  } rx_state_t;
endpackage

// ---- rx_packet_buffer.sv ----
// Single-packet receive buffer held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module rx_packet_buffer #(
  parameter int DEPTH = 128
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic wr_en_i,
  input wire logic [6:0] wr_idx_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [6:0] rd_idx_i,
  output logic [7:0] rd_data_o,
  output logic [DEPTH-1:0][7:0] mem_o
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
  } buf_state_t;
  buf_state_t cur_ff;
  buf_state_t nxt_cur;

  // One byte written per cycle by the receive engine
  always_comb begin
    nxt_cur = cur_ff;
    if (wr_en_i) begin
      nxt_cur.mem[wr_idx_i] = wr_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Second port: host reads never disturb the write side
  assign rd_data_o = cur_ff.mem[rd_idx_i];
  assign mem_o = cur_ff.mem;
endmodule
`default_nettype wire

// ---- rx_addr_filter.sv ----
// Reception mode and frame type acceptance of a stored frame
`timescale 1ns/1ps
`default_nettype none
`include "rx_filter_cfg.svh"
module rx_addr_filter #(
  parameter int DEPTH = 128
) (
  input wire logic [DEPTH-1:0][7:0] mem_i,
  input wire logic [1:0] mode_i,
  input wire logic [2:0] filt_i,
  input wire logic coord_i,
  input wire logic crc_ok_i,
  input wire logic [15:0] pan_i,
  input wire logic [15:0] short_i,
  input wire logic [63:0] ext_i,
  output logic accept_o
);
  logic [15:0] fc, span, dpan, dshort;
  logic [63:0] dext;
  logic [2:0] ftype;
  logic [1:0] dmode, smode;
  logic [7:0] soff;
  logic legal, addr_ok, mode_ok, type_ok, pan_ok;

  // Little-endian 16-bit field fetch
  function automatic logic [15:0] get16(input logic [DEPTH-1:0][7:0] m,
                                        input logic [7:0] i);
    return {m[i + 8'h01], m[i]};
  endfunction

  always_comb begin
    fc = get16(mem_i, `RFC_OFF_FC);
    ftype = fc[2:0];
    dmode = fc[11:10];
    smode = fc[15:14];
    dpan = get16(mem_i, `RFC_OFF_DPAN);
    dshort = get16(mem_i, `RFC_OFF_DADR);
    for (int k = 0; k < 8; k++) begin
      dext[8*k +: 8] = mem_i[`RFC_OFF_DADR + 8'(k)];
    end
    // Source PAN follows the destination fields unless compressed
    soff = (dmode == `RFC_AM_NONE) ? `RFC_OFF_DPAN :
           (`RFC_OFF_DADR + ((dmode == `RFC_AM_EXT) ? `RFC_LEN_EXT : `RFC_LEN_SHORT));
    span = (fc[`RFC_FC_PANC] && dmode != `RFC_AM_NONE) ? dpan : get16(mem_i, soff);
    legal = (ftype <= `RFC_FT_CMD) && (dmode != `RFC_AM_RSVD) && (smode != `RFC_AM_RSVD); // [RL3]
    addr_ok = 1'b1;
    if (ftype == `RFC_FT_BEACON) begin
      addr_ok = (span == pan_i) || (pan_i == `RFC_BCAST); // [RL4]
    end
    pan_ok = (dpan == pan_i) || (dpan == `RFC_BCAST);
    if (dmode != `RFC_AM_NONE && !pan_ok) begin
      addr_ok = 1'b0; // [RL5]
    end
    if (dmode == `RFC_AM_SHORT && dshort != short_i && dshort != `RFC_BCAST) begin
      addr_ok = 1'b0; // [RL6]
    end
    if (dmode == `RFC_AM_EXT && dext != ext_i) begin
      addr_ok = 1'b0; // [RL6]
    end
    if (dmode == `RFC_AM_NONE && smode != `RFC_AM_NONE &&
        (ftype == `RFC_FT_DATA || ftype == `RFC_FT_CMD) &&
        !(coord_i && span == pan_i)) begin
      addr_ok = 1'b0; // [RL7]
    end
    // Code 11 is not documented; it behaves like error mode
    case (mode_i)
      `RFC_MODE_NORMAL: mode_ok = crc_ok_i && legal && addr_ok; // [RL3]
      `RFC_MODE_PROMI: mode_ok = crc_ok_i; // [RL9]
      `RFC_MODE_ERROR: mode_ok = 1'b1; // [RL8]
      default: mode_ok = 1'b1;
    endcase
    // Each filter bit admits one type; all clear admits everything
    type_ok = (filt_i == 3'h0) ||
              (filt_i[2] && ftype == `RFC_FT_CMD) ||
              (filt_i[1] && ftype == `RFC_FT_DATA) ||
              (filt_i[0] && ftype == `RFC_FT_BEACON); // [RL10]
    accept_o = mode_ok && type_ok;
  end
endmodule
`default_nettype wire

// ---- rx_filter_checker.sv ----
// Port assertions for the receive frame filter and buffer
`timescale 1ns/1ps
`default_nettype none
module rx_filter_checker (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [11:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic rx_end_i,
  input wire logic ack_req_o,
  input wire logic [7:0] ack_seq_o,
  input wire logic rx_busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Frame end seen while the engine owns a frame
  sequence closed_s;
    rx_end_i && rx_busy_o;
  endsequence
  // Quality, strength and decision cycles, then idle again
  sequence tail_s;
    rx_busy_o [*3] ##1 !rx_busy_o;
  endsequence
  // Aligned words of the buffer window never answer with an error
  logic in_buf;
  assign in_buf = (paddr_i[1:0] == 2'b00) && (paddr_i[11:2] >= 10'h300) &&
                  (paddr_i[11:2] <= 10'h38F);
  a_busy_tail: assert property (closed_s |=> tail_s)
    else $error("engine tail length wrong");
  a_ack_timing: assert property (ack_req_o |-> $past(rx_end_i, 4) && $past(rx_busy_o))
    else $error("acknowledge not four cycles after frame end");
  a_ack_pulse: assert property (ack_req_o |=> !ack_req_o)
    else $error("acknowledge request longer than one cycle");
  a_seq_hold: assert property ($changed(ack_seq_o) |-> ack_req_o)
    else $error("acknowledge sequence changed without a request");
  a_ready_high: assert property (pready_o)
    else $error("register port inserted a wait state");
  a_err_phase: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("error response outside access phase");
  a_buf_mapped: assert property (psel_i && penable_i && in_buf |-> !pslverr_o)
    else $error("buffer word answered with an error");
  a_reset_idle: assert property ($fell(reset_i) |-> !rx_busy_o && !ack_req_o && ack_seq_o == 8'h00)
    else $error("engine not idle after reset");
endmodule
bind rx_frame_filter_buffer rx_filter_checker u_rx_filter_checker (.clk_i(clk_i),
  .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_end_i(rx_end_i), .ack_req_o(ack_req_o),
  .ack_seq_o(ack_seq_o), .rx_busy_o(rx_busy_o));
`default_nettype wire

// ---- rx_frame_source.sv ----
// Demodulator model that delivers one frame on request
`timescale 1ns/1ps
`default_nettype none
module rx_frame_source (
  input wire logic clk_i,
  output logic sync_o,
  output logic valid_o,
  output logic [7:0] byte_o,
  output logic end_o,
  output logic crc_o,
  output logic [7:0] lqi_o,
  output logic [7:0] rssi_o
);
  // Quiet link at time zero
  initial {sync_o, valid_o, end_o, crc_o} = 4'h0;
  initial {byte_o, lqi_o, rssi_o} = 24'h00_0000;
  // Sync, the whole frame back to back, then the end marker with CRC status
  task automatic send(input logic [7:0] f [9], input logic crc);
    sync_o <= 1'b1;
    @(posedge clk_i);
    sync_o <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      valid_o <= 1'b1;
      byte_o <= f[i];
      @(posedge clk_i);
    end
    valid_o <= 1'b0;
    byte_o <= ~f[8];
    end_o <= 1'b1;
    crc_o <= crc;
    lqi_o <= 8'h5A;
    rssi_o <= 8'hA5;
    @(posedge clk_i);
    // Stale qualifiers flip, so a late sample cannot pass by luck
    end_o <= 1'b0;
    crc_o <= ~crc;
    lqi_o <= 8'hA5;
    rssi_o <= 8'h5A;
    repeat (6) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ---- rx_frame_filter_buffer_tb_top.sv ----
// Self-checking bench for the receive frame filter and buffer
`timescale 1ns/1ps
`default_nettype none
module rx_frame_filter_buffer_tb_top;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, ack_req_o, rx_busy_o, err;
  logic rx_sync_i, rx_byte_valid_i, rx_end_i, rx_crc_ok_i;
  logic [7:0] rx_byte_i, rx_lqi_i, rx_rssi_i, ack_seq_o;
  logic [7:0] frm [9];
  logic [31:0] v;
  int mismatches = 0;
  int check_count = 0;
  int acks = 0;
  always #5 clk_i = ~clk_i;
  rx_frame_filter_buffer u_rx_frame_filter_buffer (.clk_i, .reset_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rx_sync_i,
    .rx_byte_valid_i, .rx_byte_i, .rx_end_i, .rx_crc_ok_i, .rx_lqi_i, .rx_rssi_i,
    .ack_req_o, .ack_seq_o, .rx_busy_o);
  rx_frame_source u_rx_frame_source (.clk_i(clk_i), .sync_o(rx_sync_i),
    .valid_o(rx_byte_valid_i), .byte_o(rx_byte_i), .end_o(rx_end_i), .crc_o(rx_crc_ok_i),
    .lqi_o(rx_lqi_i), .rssi_o(rx_rssi_i));
  // Count acknowledge pulses handed to the transmit side
  always @(posedge clk_i) if (ack_req_o === 1'b1) acks++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; an idle cycle follows so psel never toggles twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    v = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(v, e);
  endtask
  // Frame with given control bytes, sequence and PAN; address 0x5678 follows
  task automatic rxf(input logic [7:0] fc0, input logic [7:0] fc1, input logic [7:0] seq,
                     input logic [15:0] pan, input logic crc);
    frm = '{fc0, fc1, seq, pan[7:0], pan[15:8], 8'h78, 8'h56, 8'hC3, 8'h3C};
    u_rx_frame_source.send(frm, crc);
  endtask
  // Data frame, acknowledge requested, short destination 0x5678
  task automatic rx(input logic [7:0] seq, input logic [15:0] pan, input logic crc);
    rxf(8'h21, 8'h08, seq, pan, crc);
  endtask
  task automatic t_reset;
    rdc(12'h000, 32'h0000_0000);
    rdc(12'h034, 32'h0000_0000);
    rdc(12'h0FC, 32'h0000_0000);
    chk(err, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_promisc;
    apb(1'b1, 12'h000, 32'h0000_0001);
    rx(8'h37, 16'hBEEF, 1'b1);
    chk(acks, 1);
    chk(ack_seq_o, 8'h37);
    rdc(12'h0C4, 32'h0000_0008);
    rdc(12'h0C4, 32'h0000_0000);
    rdc(12'hC00, 32'h0000_0009);
    rdc(12'hC0C, 32'h0000_0037);
    rdc(12'hC28, 32'h0000_005A);
    rdc(12'hC2C, 32'h0000_00A5);
    $display("test promiscuous done");
  endtask
  task automatic t_modes;
    apb(1'b1, 12'h000, 32'h0000_0000);
    apb(1'b1, 12'h100, 32'h0000_1234);
    apb(1'b1, 12'h104, 32'h0000_5678);
    rx(8'h41, 16'h4321, 1'b1);
    rdc(12'h0C4, 32'h0000_0000);
    rx(8'h42, 16'hFFFF, 1'b0);
    rdc(12'h0C4, 32'h0000_0000);
    rx(8'h43, 16'hFFFF, 1'b1);
    rdc(12'h0C4, 32'h0000_0008);
    chk(ack_seq_o, 8'h43);
    rdc(12'hC00, 32'h0000_0009);
    apb(1'b1, 12'h000, 32'h0000_0002);
    rx(8'h44, 16'h1234, 1'b0);
    rdc(12'h0C4, 32'h0000_0008);
    chk(acks, 2);
    rdc(12'hC00, 32'h0000_0009);
    apb(1'b1, 12'h000, 32'h0000_0001);
    rx(8'h45, 16'h1234, 1'b0);
    rdc(12'h0C4, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0003);
    rx(8'h46, 16'h1234, 1'b0);
    rdc(12'h0C4, 32'h0000_0008);
    rdc(12'hC00, 32'h0000_0009);
    apb(1'b1, 12'h000, 32'h0000_0001);
    $display("test modes done");
  endtask
  task automatic t_filter;
    apb(1'b1, 12'h034, 32'h0000_0008);
    rx(8'h51, 16'h1234, 1'b1);
    rdc(12'h0C4, 32'h0000_0000);
    apb(1'b1, 12'h034, 32'h0000_0004);
    rx(8'h52, 16'h1234, 1'b1);
    rdc(12'h0C4, 32'h0000_0008);
    rdc(12'hC00, 32'h0000_0009);
    apb(1'b1, 12'h034, 32'h0000_0000);
    $display("test filter done");
  endtask
  task automatic t_hold;
    rx(8'h61, 16'h1234, 1'b1);
    rdc(12'h0C4, 32'h0000_0008);
    rx(8'h62, 16'h1234, 1'b1);
    rdc(12'h0C4, 32'h0000_0000);
    chk(ack_seq_o, 8'h61);
    rdc(12'hC0C, 32'h0000_0061);
    apb(1'b1, 12'h034, 32'h0000_0001);
    rdc(12'h034, 32'h0000_0000);
    rx(8'h63, 16'h1234, 1'b1);
    rdc(12'h0C4, 32'h0000_0008);
    rdc(12'hC00, 32'h0000_0009);
    apb(1'b1, 12'h0E4, 32'h0000_0004);
    rx(8'h64, 16'h1234, 1'b1);
    rdc(12'h0C4, 32'h0000_0000);
    apb(1'b1, 12'h0E4, 32'h0000_0000);
    rx(8'h65, 16'h1234, 1'b1);
    rdc(12'h0C4, 32'h0000_0008);
    apb(1'b1, 12'h0A8, 32'h0000_0001);
    rx(8'h66, 16'h1234, 1'b1);
    rdc(12'h0C4, 32'h0000_0008);
    rdc(12'hC0C, 32'h0000_0066);
    $display("test hold done");
  endtask
  // Beacon and source-only frames under normal mode filtering
  task automatic t_addr;
    apb(1'b1, 12'h034, 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h0000_0000);
    rxf(8'h00, 8'h80, 8'h71, 16'h4321, 1'b1);
    rdc(12'h0C4, 32'h0000_0000);
    rxf(8'h00, 8'h80, 8'h72, 16'h1234, 1'b1);
    rdc(12'h0C4, 32'h0000_0008);
    rdc(12'hC00, 32'h0000_0009);
    rxf(8'h01, 8'h80, 8'h73, 16'h1234, 1'b1);
    rdc(12'h0C4, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0008);
    rdc(12'h000, 32'h0000_0008);
    rxf(8'h01, 8'h80, 8'h74, 16'h1234, 1'b1);
    rdc(12'h0C4, 32'h0000_0008);
    rdc(12'hC0C, 32'h0000_0074);
    $display("test addressing done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Main sequence after an eight-cycle reset
  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_promisc();
    t_modes();
    t_filter();
    t_hold();
    t_addr();
    give_verdict();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
